// [mcr_pkg.sv]
// constants of the byte-wide configuration register area
// assumes a 40 MHz core clock and decoded register requests from the serial front end
package mcr_pkg;

    // ==============================================================
    // geometry of the configuration area
    localparam int unsigned AREA_BYTES = 256;
    localparam int unsigned IDX_W      = 8;
    // protocol address of the first configuration register (register number minus one)
    localparam logic [15:0] AREA_BASE  = 16'h0100;
    localparam logic [15:0] AREA_LAST  = 16'h01FF;

    // ==============================================================
    // register numbers of the named registers
    localparam logic [15:0] REG_DEVICE_TYPE_ID       = 16'h0101;
    localparam logic [15:0] REG_FIRMWARE_REVISION    = 16'h0102;
    localparam logic [15:0] REG_SERIAL_NUMBER_FIRST  = 16'h0103;
    localparam logic [15:0] REG_SERIAL_NUMBER_SECOND = 16'h0104;
    localparam logic [15:0] REG_PULLUP_ENABLE        = 16'h0111;
    localparam logic [15:0] REG_SERIAL_LINK_CONFIG   = 16'h0112;
    localparam logic [15:0] REG_SLAVE_ADDRESS        = 16'h0113;
    localparam logic [15:0] REG_IO_DIRECTION         = 16'h0114;

    // ==============================================================
    // byte indices inside the area
    localparam logic [7:0] IDX_DEVICE_TYPE   = 8'(REG_DEVICE_TYPE_ID - 16'h0101);
    localparam logic [7:0] IDX_FW_REVISION   = 8'(REG_FIRMWARE_REVISION - 16'h0101);
    localparam logic [7:0] IDX_SERIAL_FIRST  = 8'(REG_SERIAL_NUMBER_FIRST - 16'h0101);
    localparam logic [7:0] IDX_SERIAL_SECOND = 8'(REG_SERIAL_NUMBER_SECOND - 16'h0101);
    localparam logic [7:0] IDX_ID_LAST       = 8'h07;
    localparam logic [7:0] IDX_ONCE_LAST     = 8'h0F;
    localparam logic [7:0] IDX_CFG_FIRST     = 8'(REG_PULLUP_ENABLE - 16'h0101);
    localparam logic [7:0] IDX_CFG_LAST      = 8'h1F;
    localparam int unsigned CFG_LIVE         = 4;

    // ==============================================================
    // field positions and values
    localparam int unsigned BIT_PULLUP  = 0;
    localparam int unsigned BIT_BAUD    = 0;
    localparam int unsigned BIT_WIEGAND = 6;
    localparam int unsigned BIT_PARITY  = 7;
    localparam logic [7:0]  ERASED_BYTE = 8'hFF;
    localparam logic [7:0]  ID_RESERVED_VALUE = 8'hFF;

    // ==============================================================
    // silence timeout
    localparam int unsigned CLK_HZ         = 40000000;
    localparam int unsigned SILENCE_TIME_S = 5;
    localparam int unsigned SILENCE_CYCLES = SILENCE_TIME_S * CLK_HZ;
    localparam int unsigned SILENCE_W      = 32;
    localparam logic [2:0]  LOAD_DONE      = 3'h4;

    typedef enum logic [1:0] {
        ST_LOAD   = 2'b00,
        ST_IDLE   = 2'b01,
        ST_ACCESS = 2'b10
    } mcr_state_t;

endpackage

// [mcr_mem_if.sv]
// carrier between the register bank and its byte store
// assumes one clock domain; read data appear one edge after the address
interface mcr_mem_if;
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport ctrl (output we, output addr, output wdata, input rdata);
    modport store (input we, input addr, input wdata, output rdata);
endinterface

// [mcr_byte_store.sv]
// 256 x 8 byte store standing in for the non-volatile configuration memory
// assumes the controller holds the address for the read cycle
module mcr_byte_store (
    input  wire logic  clock_i,
    mcr_mem_if.store   mem
);
    // ==============================================================
    // array
    // no reset on purpose: contents model storage that outlives restarts
    logic [7:0] mem_ff [mcr_pkg::AREA_BYTES];
    logic [7:0] rdata_ff;

    // plain always: an erased image may be loaded into the array from outside
    always @(posedge clock_i) begin
        if (mem.we) begin
            mem_ff[mem.addr] <= mem.wdata;
        end
    end

    always_ff @(posedge clock_i) begin
        rdata_ff <= mem_ff[mem.addr];
    end

    assign mem.rdata = rdata_ff;
endmodule

// [mcr_config_bank.sv]
// configuration and identity register area served to the bus master
// assumes a front end that decodes register read/write requests into req_* pulses
//
// Operation
// - 256 bytes at registers 257 to 512
// - only low byte stored, upper bits zero
// - first sixteen bytes lock once not 0xFF, but 257-264 never take a write
// - bytes 257-264 identity, read-only
// - 257 returns fixed device type byte
// - 258 revision, 259/260 serial number bytes
// - 261-264 reserved identity, read-only
// - 265-272 installer write-once storage
// - 273-288 are configuration registers
// - 289-512 free user byte storage
// - reload link settings after five silent seconds
// - 273 value 1 enables pull-ups
// - 274 bit0 selects 19200 or 9600 baud
// - 274 bit6 enables reader support
// - 274 bit7 selects even or no parity
// - 275 holds own slave address
// - 276 per-line direction, 1 means output
// - 277-288 reserved, plain storage
// - access only via register read/write
// - unimplemented location answers with exception
module mcr_config_bank #(
    parameter logic [7:0]  DEVICE_TYPE_ID = 8'h5A, // arbitrary value
    parameter logic [7:0]  FW_REVISION    = 8'h01, // arbitrary value
    parameter int unsigned SILENCE_CYCLES = mcr_pkg::SILENCE_CYCLES
) (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        req_valid_i,
    output logic             req_ready_o,
    input  wire logic        req_write_i,
    input  wire logic [15:0] req_addr_i,
    input  wire logic [15:0] req_wdata_i,
    output logic             rsp_valid_o,
    output logic [15:0]      rsp_data_o,
    output logic             rsp_exception_o,
    input  wire logic        valid_traffic_i,
    input  wire logic [15:0] serial_number_i,
    output logic             pullup_enable_o,
    output logic [7:0]       io_direction_o,
    output logic             baud_9600_o,
    output logic             parity_none_o,
    output logic             wiegand_enable_o,
    output logic [7:0]       slave_address_o,
    output logic             comm_reload_o
);

    // ==============================================================
    // decode helpers
    typedef enum logic [2:0] {
        RG_ID     = 3'b000,
        RG_ONCE   = 3'b001,
        RG_CFG    = 3'b010,
        RG_USER   = 3'b011,
        RG_NONE   = 3'b100
    } mcr_region_t;

    function automatic logic in_area(input logic [15:0] addr);
        in_area = (addr >= mcr_pkg::AREA_BASE) && (addr <= mcr_pkg::AREA_LAST);
    endfunction

    function automatic mcr_region_t region_of(input logic [7:0] idx);
        if (idx <= mcr_pkg::IDX_ID_LAST) begin
            region_of = RG_ID;
        end else if (idx <= mcr_pkg::IDX_ONCE_LAST) begin
            region_of = RG_ONCE;
        end else if (idx <= mcr_pkg::IDX_CFG_LAST) begin
            region_of = RG_CFG;
        end else begin
            region_of = RG_USER;
        end
    endfunction

    // ==============================================================
    // request capture
    mcr_mem_if mem ();

    mcr_pkg::mcr_state_t state_ff;
    mcr_pkg::mcr_state_t nxt_state;
    logic [2:0]          load_idx_ff;
    logic                req_write_ff;
    logic                req_hit_ff;
    logic [7:0]          req_idx_ff;
    logic [7:0]          req_wdata_ff;
    logic                req_take;
    logic [7:0]          req_idx;
    logic                load_capture;
    logic                load_done;

    assign req_ready_o = (state_ff == mcr_pkg::ST_IDLE);
    assign req_take    = req_valid_i && req_ready_o;
    // protocol address minus the area base gives the byte index
    assign req_idx      = 8'(req_addr_i - mcr_pkg::AREA_BASE);
    assign load_capture = (state_ff == mcr_pkg::ST_LOAD) && (load_idx_ff != 3'h0);
    assign load_done    = (state_ff == mcr_pkg::ST_LOAD) && (load_idx_ff == mcr_pkg::LOAD_DONE);

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            req_write_ff <= 1'b0;
            req_hit_ff   <= 1'b0;
            req_idx_ff   <= 8'h00;
            req_wdata_ff <= 8'h00;
        end else if (req_take) begin
            req_write_ff <= req_write_i;
            req_hit_ff   <= in_area(req_addr_i);
            req_idx_ff   <= req_idx;
            req_wdata_ff <= req_wdata_i[7:0];
        end
    end

    // ==============================================================
    // sequencer
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            mcr_pkg::ST_LOAD: begin
                if (load_done) begin
                    nxt_state = mcr_pkg::ST_IDLE;
                end
            end
            mcr_pkg::ST_IDLE: begin
                if (req_take) begin
                    nxt_state = mcr_pkg::ST_ACCESS;
                end
            end
            mcr_pkg::ST_ACCESS: begin
                nxt_state = mcr_pkg::ST_IDLE;
            end
            default: begin
                nxt_state = mcr_pkg::ST_LOAD;
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= mcr_pkg::ST_LOAD;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // stored settings are pulled out of the store after every reset
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            load_idx_ff <= 3'h0;
        end else if ((state_ff == mcr_pkg::ST_LOAD) && !load_done) begin
            load_idx_ff <= load_idx_ff + 3'h1;
        end
    end

    // ==============================================================
    // store access
    mcr_region_t acc_region;
    logic        once_open;
    logic        store_write;

    assign acc_region = req_hit_ff ? region_of(req_idx_ff) : RG_NONE;
    // write-once bytes accept a write only while still erased
    assign once_open  = (mem.rdata == mcr_pkg::ERASED_BYTE);
    assign store_write = (state_ff == mcr_pkg::ST_ACCESS) && req_write_ff
                         && ((acc_region == RG_CFG) || (acc_region == RG_USER)
                             || ((acc_region == RG_ONCE) && once_open));

    always_comb begin
        mem.we    = store_write;
        mem.wdata = req_wdata_ff;
        unique case (state_ff)
            mcr_pkg::ST_LOAD:   mem.addr = mcr_pkg::IDX_CFG_FIRST + {6'h00, load_idx_ff[1:0]};
            mcr_pkg::ST_IDLE:   mem.addr = req_idx;
            mcr_pkg::ST_ACCESS: mem.addr = req_idx_ff;
            default:            mem.addr = req_idx_ff;
        endcase
    end

    mcr_byte_store u_store (
        .clock_i (clock_i),
        .mem     (mem)
    );

    // ==============================================================
    // identity bytes
    // identity comes from constants and pins, never from the store, so no write can alter it
    logic [7:0] id_byte;

    always_comb begin
        unique case (req_idx_ff[2:0])
            mcr_pkg::IDX_DEVICE_TYPE[2:0]:   id_byte = DEVICE_TYPE_ID;
            mcr_pkg::IDX_FW_REVISION[2:0]:   id_byte = FW_REVISION;
            mcr_pkg::IDX_SERIAL_FIRST[2:0]:  id_byte = serial_number_i[7:0];
            mcr_pkg::IDX_SERIAL_SECOND[2:0]: id_byte = serial_number_i[15:8];
            default:                         id_byte = mcr_pkg::ID_RESERVED_VALUE;
        endcase
    end

    // ==============================================================
    // answer
    logic [7:0] acc_byte;

    always_comb begin
        if (acc_region == RG_ID) begin
            acc_byte = id_byte;
        end else if (req_write_ff && store_write) begin
            acc_byte = req_wdata_ff;
        end else begin
            acc_byte = mem.rdata;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rsp_valid_o <= 1'b0;
        end else begin
            rsp_valid_o <= (state_ff == mcr_pkg::ST_ACCESS);
        end
    end

    // flag and data hold until the next answer
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rsp_exception_o <= 1'b0;
        end else if (state_ff == mcr_pkg::ST_ACCESS) begin
            rsp_exception_o <= (acc_region == RG_NONE);
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rsp_data_o <= 16'h0000;
        end else if (state_ff == mcr_pkg::ST_ACCESS) begin
            // upper byte always reads as zero
            rsp_data_o <= (acc_region == RG_NONE) ? 16'h0000 : {8'h00, acc_byte};
        end
    end

    // ==============================================================
    // live copies of the first configuration bytes
    logic [7:0] cfg_ff [mcr_pkg::CFG_LIVE];

    genvar k;
    generate
        for (k = 0; k < mcr_pkg::CFG_LIVE; k++) begin : g_cfg
            localparam logic [7:0] CFG_IDX = mcr_pkg::IDX_CFG_FIRST + 8'(k);
            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    cfg_ff[k] <= 8'h00;
                end else if (load_capture && (load_idx_ff == 3'(k + 1))) begin
                    cfg_ff[k] <= mem.rdata;
                end else if (store_write && (req_idx_ff == CFG_IDX)) begin
                    cfg_ff[k] <= req_wdata_ff;
                end
            end
        end
    endgenerate

    // pull-ups and directions follow the stored bytes at once
    assign pullup_enable_o = cfg_ff[0][mcr_pkg::BIT_PULLUP];
    assign io_direction_o  = cfg_ff[3];

    // ==============================================================
    // silence watchdog
    logic [mcr_pkg::SILENCE_W-1:0] silence_cnt_ff;
    logic                          silence_hit;

    // counter restarts at the hit, so reloads repeat while the link stays quiet
    assign silence_hit = (silence_cnt_ff == mcr_pkg::SILENCE_W'(SILENCE_CYCLES - 1));

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            silence_cnt_ff <= '0;
        end else if (valid_traffic_i || silence_hit) begin
            silence_cnt_ff <= '0;
        end else begin
            silence_cnt_ff <= silence_cnt_ff + 1'b1;
        end
    end

    // ==============================================================
    // active link settings
    // written link bytes act only at reload, so a bad setting cannot cut the master off for good
    logic       reload;
    logic       baud_ff;
    logic       parity_ff;
    logic       wiegand_ff;
    logic [7:0] slave_ff;
    logic       reload_ff;

    assign reload = load_done || silence_hit;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            baud_ff <= 1'b0;
        end else if (reload) begin
            baud_ff <= cfg_ff[1][mcr_pkg::BIT_BAUD];
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wiegand_ff <= 1'b0;
        end else if (reload) begin
            wiegand_ff <= cfg_ff[1][mcr_pkg::BIT_WIEGAND];
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            parity_ff <= 1'b0;
        end else if (reload) begin
            parity_ff <= cfg_ff[1][mcr_pkg::BIT_PARITY];
        end
    end

    // address follows the same reload, so frames stay answered until then
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            slave_ff <= 8'h00;
        end else if (reload) begin
            slave_ff <= cfg_ff[2];
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            reload_ff <= 1'b0;
        end else begin
            reload_ff <= reload;
        end
    end

    assign baud_9600_o      = baud_ff;
    assign parity_none_o    = parity_ff;
    assign wiegand_enable_o = wiegand_ff;
    assign slave_address_o  = slave_ff;
    assign comm_reload_o    = reload_ff;

endmodule

// [mcr_config_bank_assertions.sv]
// port assertions for the configuration register bank
// assumes one clock, reset asynchronous and active high
module mcr_config_bank_checker #(
    parameter logic [7:0]  DEVICE_TYPE_ID = 8'h5A,
    parameter int unsigned SILENCE_CYCLES = 20
) (
    input wire logic        clock_i,
    input wire logic        rst_i,
    input wire logic        req_valid_i,
    input wire logic        req_ready_o,
    input wire logic        req_write_i,
    input wire logic [15:0] req_addr_i,
    input wire logic [15:0] req_wdata_i,
    input wire logic        rsp_valid_o,
    input wire logic [15:0] rsp_data_o,
    input wire logic        rsp_exception_o,
    input wire logic        valid_traffic_i,
    input wire logic [15:0] serial_number_i,
    input wire logic        pullup_enable_o,
    input wire logic [7:0]  io_direction_o,
    input wire logic        baud_9600_o,
    input wire logic        parity_none_o,
    input wire logic        wiegand_enable_o,
    input wire logic [7:0]  slave_address_o,
    input wire logic        comm_reload_o
);
    // ==============================================================
    // helpers; silence bound has slack for the reload latency
    logic        take;
    logic        in_area;
    logic [31:0] cnt_ff;
    assign take    = req_valid_i && req_ready_o;
    assign in_area = req_addr_i[15:8] == 8'h01;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= 32'h0;
        end else if (valid_traffic_i || comm_reload_o) begin
            cnt_ff <= 32'h0;
        end else begin
            cnt_ff <= cnt_ff + 32'h1;
        end
    end

    // ==============================================================
    // assertions
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    a_answer_timing: assert property (take |=> !req_ready_o ##1 (rsp_valid_o && req_ready_o))
        else $error("answer not two cycles after request");
    a_area_normal: assert property (take && in_area |-> ##2 (!rsp_exception_o && rsp_data_o[15:8] == 8'h00))
        else $error("area access answered wrongly");
    a_outside_exc: assert property (take && !in_area |-> ##2 (rsp_exception_o && rsp_data_o == 16'h0000))
        else $error("outside access without exception");
    a_type_byte: assert property (take && req_addr_i == 16'h0100 |-> ##2 rsp_data_o == {8'h00, DEVICE_TYPE_ID})
        else $error("device type byte wrong");
    a_serial_bytes: assert property (take && req_addr_i[15:1] == 15'h0081 |-> ##2
        rsp_data_o[7:0] == ($past(req_addr_i[0], 2) ? serial_number_i[15:8] : serial_number_i[7:0]))
        else $error("serial number byte wrong");
    a_pullup_live: assert property (take && req_write_i && req_addr_i == 16'h0110 |-> ##2
        pullup_enable_o == $past(req_wdata_i[0], 2))
        else $error("pull-up enable not following write");
    a_dir_live: assert property (take && req_write_i && req_addr_i == 16'h0113 |-> ##2
        io_direction_o == $past(req_wdata_i[7:0], 2))
        else $error("direction not following write");
    a_link_hold: assert property (($changed(baud_9600_o) || $changed(parity_none_o)
        || $changed(wiegand_enable_o) || $changed(slave_address_o)) |-> comm_reload_o)
        else $error("link setting changed outside reload");
    a_silence_bound: assert property (cnt_ff <= SILENCE_CYCLES + 3)
        else $error("no reload after silence");
endmodule

bind mcr_config_bank mcr_config_bank_checker #(
    .DEVICE_TYPE_ID(DEVICE_TYPE_ID), .SILENCE_CYCLES(SILENCE_CYCLES)
) i_mcr_config_bank_checker (
    .clock_i(clock_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rsp_exception_o(rsp_exception_o),
    .valid_traffic_i(valid_traffic_i), .serial_number_i(serial_number_i),
    .pullup_enable_o(pullup_enable_o), .io_direction_o(io_direction_o),
    .baud_9600_o(baud_9600_o), .parity_none_o(parity_none_o),
    .wiegand_enable_o(wiegand_enable_o), .slave_address_o(slave_address_o),
    .comm_reload_o(comm_reload_o)
);

// [mcr_master_model.sv]
// bus master model issuing decoded register requests
// assumes the bank answers two edges after taking a request
module mcr_master_model (
    input  wire logic        clock_i,
    input  wire logic        req_ready_i,
    input  wire logic        rsp_valid_i,
    input  wire logic [15:0] rsp_data_i,
    input  wire logic        rsp_exception_i,
    output logic             req_valid_o,
    output logic             req_write_o,
    output logic [15:0]      req_addr_o,
    output logic [15:0]      req_wdata_o,
    output logic             valid_traffic_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        req_valid_o     = 1'b0;
        req_write_o     = 1'b0;
        req_addr_o      = 16'h0000;
        req_wdata_o     = 16'h0000;
        valid_traffic_o = 1'b0;
    end

    // ==============================================================
    // one register read or write; released lines are inverted, not held
    task automatic xfer(input logic wr, input int unsigned r, input logic [15:0] wd,
                        output logic [15:0] rd, output logic exc);
        int n;
        n = 0;
        @(posedge clock_i);
        #2;
        req_valid_o     = 1'b1;
        req_write_o     = wr;
        req_addr_o      = 16'(r - 1);
        req_wdata_o     = wd;
        valid_traffic_o = 1'b1;
        do begin
            @(posedge clock_i);
            n++;
        end while (req_ready_i !== 1'b1 && n < 50);
        #2;
        req_valid_o     = 1'b0;
        valid_traffic_o = 1'b0;
        req_addr_o      = ~req_addr_o;
        req_wdata_o     = ~req_wdata_o;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (rsp_valid_i !== 1'b1 && n < 8);
        // a missing answer reads as unknown so the compare fails
        rd  = (rsp_valid_i === 1'b1) ? rsp_data_i : 16'hXXXX;
        exc = (rsp_valid_i === 1'b1) ? rsp_exception_i : 1'bX;
    endtask
endmodule

// [tb_mcr_config_bank.sv]
// self-checking bench for the configuration register bank
// assumes the byte store may be preloaded through hierarchy as erased memory
module tb_mcr_config_bank;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0]  TYPE_ID = 8'h3C; // arbitrary value
    localparam logic [7:0]  FW_REV  = 8'h21; // arbitrary value
    localparam logic [15:0] SER     = 16'h9E47;
    localparam int unsigned SIL     = 20;
    logic clock_i, rst_i, req_valid_i, req_ready_o, req_write_i, rsp_valid_o, rsp_exception_o;
    logic valid_traffic_i, pullup_enable_o, baud_9600_o, parity_none_o, wiegand_enable_o;
    logic comm_reload_o, exc;
    logic [15:0] req_addr_i, req_wdata_i, rsp_data_o, rd;
    logic [7:0]  io_direction_o, slave_address_o;
    logic [7:0]  id_exp [8];
    int          errors, tests_run;

    mcr_config_bank #(.DEVICE_TYPE_ID(TYPE_ID), .FW_REVISION(FW_REV), .SILENCE_CYCLES(SIL))
    i_mcr_config_bank (
        .clock_i(clock_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
        .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rsp_exception_o(rsp_exception_o),
        .valid_traffic_i(valid_traffic_i), .serial_number_i(SER),
        .pullup_enable_o(pullup_enable_o), .io_direction_o(io_direction_o),
        .baud_9600_o(baud_9600_o), .parity_none_o(parity_none_o),
        .wiegand_enable_o(wiegand_enable_o), .slave_address_o(slave_address_o),
        .comm_reload_o(comm_reload_o));
    mcr_master_model i_mcr_master_model (
        .clock_i(clock_i), .req_ready_i(req_ready_o), .rsp_valid_i(rsp_valid_o),
        .rsp_data_i(rsp_data_o), .rsp_exception_i(rsp_exception_o), .req_valid_o(req_valid_i),
        .req_write_o(req_write_i), .req_addr_o(req_addr_i), .req_wdata_o(req_wdata_i),
        .valid_traffic_o(valid_traffic_i));

    // ==============================================================
    // tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic wr, input int unsigned r, input logic [15:0] wd,
                       input logic [15:0] exp, input logic exp_exc);
        i_mcr_master_model.xfer(wr, r, wd, rd, exc);
        check(rd, exp);
        check({15'h0, exc}, {15'h0, exp_exc});
    endtask
    // link settings packed as baud, parity, reader, address
    function automatic logic [15:0] link();
        return {5'h0, baud_9600_o, parity_none_o, wiegand_enable_o, slave_address_o};
    endfunction
    task automatic wait_reload(input logic [15:0] exp);
        int n;
        n = 0;
        while (comm_reload_o !== 1'b1 && n < 100) begin
            @(posedge clock_i);
            n++;
        end
        #2;
        check(link(), exp);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ==============================================================
    // clock, watchdog, sequence
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    initial begin
        #(25 * 5000);
        errors++;
        finish_test();
    end
    initial begin
        errors    = 0;
        tests_run = 0;
        rst_i     = 1'b1;
        id_exp    = '{TYPE_ID, FW_REV, SER[7:0], SER[15:8], 8'hFF, 8'hFF, 8'hFF, 8'hFF};
        // erased memory, as a fresh non-volatile part would read
        for (int i = 0; i < 256; i++) begin
            i_mcr_config_bank.u_store.mem_ff[i] = 8'hFF;
        end
        repeat (12) @(posedge clock_i);
        #2;
        rst_i = 1'b0;
        wait_reload(16'h07FF);
        for (int i = 0; i < 8; i++) begin
            acc(1'b0, 257 + i, 16'h0, {8'h0, id_exp[i]}, 1'b0);
            acc(1'b1, 257 + i, 16'h0000, {8'h0, id_exp[i]}, 1'b0);
        end
        acc(1'b1, 265, 16'hAB12, 16'h0012, 1'b0);
        acc(1'b1, 265, 16'h0034, 16'h0012, 1'b0);
        acc(1'b0, 265, 16'h0000, 16'h0012, 1'b0);
        acc(1'b1, 272, 16'h00FF, 16'h00FF, 1'b0);
        acc(1'b1, 272, 16'h0077, 16'h0077, 1'b0);
        acc(1'b1, 272, 16'h0088, 16'h0077, 1'b0);
        acc(1'b1, 273, 16'hFF01, 16'h0001, 1'b0);
        #2;
        check({15'h0, pullup_enable_o}, 16'h0001);
        acc(1'b1, 273, 16'h0000, 16'h0000, 1'b0);
        #2;
        check({15'h0, pullup_enable_o}, 16'h0000);
        acc(1'b1, 276, 16'h00A5, 16'h00A5, 1'b0);
        #2;
        check({8'h0, io_direction_o}, 16'h00A5);
        acc(1'b1, 274, 16'h0040, 16'h0040, 1'b0);
        acc(1'b1, 275, 16'h0017, 16'h0017, 1'b0);
        #2;
        check(link(), 16'h07FF);
        wait_reload(16'h0117);
        acc(1'b1, 274, 16'h0081, 16'h0081, 1'b0);
        acc(1'b1, 275, 16'h00C3, 16'h00C3, 1'b0);
        wait_reload(16'h06C3);
        foreach (id_exp[i]) begin
            acc(1'b1, (i < 4) ? 277 + i * 4 : ((i == 7) ? 512 : 290 + i * 30),
                {8'hEE, id_exp[i] ^ 8'h5A}, {8'h0, id_exp[i] ^ 8'h5A}, 1'b0);
        end
        acc(1'b0, 512, 16'h0000, {8'h0, id_exp[7] ^ 8'h5A}, 1'b0);
        acc(1'b1, 256, 16'h0011, 16'h0000, 1'b1);
        acc(1'b1, 513, 16'h0022, 16'h0000, 1'b1);
        acc(1'b0, 1, 16'h0000, 16'h0000, 1'b1);
        acc(1'b0, 512, 16'h0000, {8'h0, id_exp[7] ^ 8'h5A}, 1'b0);
        finish_test();
    end
endmodule
